// ===== hdl/scp_pkg.sv
// Contract
// RULE1: controller initialises registers after power-up via reset
// RULE2: soft reset bit restores defaults, self-clears
// RULE3: controller waits 1 ms before reset pulse
// RULE4: controller waits 100 ns before first select
// RULE5: shift on sclk rise only while selected
// RULE6: every 24th rise commits word to register
// RULE7: trailing partial word is discarded
// RULE8: several words per select, each written separately
// RULE9: word is 8-bit address then 16 data
// RULE10: serial output floats after power-up or reset
// RULE11: readback enable bit turns on readout mode
// RULE12: readout mode blocks writes except register 01h
// RULE13: writing zero leaves readout mode
// RULE14: register 01h not readable in readout mode
// RULE15: read cycle address returns register data serially
// RULE16: data changes after fall, sampled on rise
// RULE17: leaving readout floats output, re-enables writes
// RULE18: all fields sent most significant bit first
package scp_pkg;
  // timing at the 20 MHz system clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_POWER_ON_NS = 1000000;
  localparam int POWER_ON_CYCLES = (T_POWER_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RESET_PULSE_NS = 50;
  // pulse must be strictly wider than the figure, so one more cycle
  localparam int RESET_PULSE_CYCLES = T_RESET_PULSE_NS / CLK_PERIOD_NS + 1;
  localparam int T_RESET_GAP_NS = 100;
  localparam int RESET_GAP_CYCLES = (T_RESET_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_BITS = 16;
  // serial word layout
  localparam int WORD_BITS = 24;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] LAST_BIT = 5'h17;
  localparam logic [CNT_BITS-1:0] ADDR_DONE_CNT = 5'h08;
  // register file
  localparam int REG_COUNT = 64;
  localparam int REG_IDX_BITS = 6;
  localparam logic [ADDR_BITS-1:0] ADDR_SOFT_RESET_CONTROL = 8'h00;
  localparam logic [ADDR_BITS-1:0] ADDR_READBACK_CONTROL = 8'h01;
  localparam int SOFT_RESET_BIT = 0;
  localparam int READBACK_EN_BIT = 0;
  localparam logic [DATA_BITS-1:0] REG_RESET = 16'h0000;
  // host serial clock: low for two cycles, high for two
  localparam logic [1:0] PHASE_RISE = 2'h1;
  localparam logic [1:0] PHASE_FALL = 2'h3;
endpackage

// ===== hdl/scp_link_if.sv
`timescale 1ns/1ps
// serial pins between controller and device; sdo only meaningful while sdo_oe is high
interface scp_link_if;
  logic cs_n;
  logic sclk;
  logic serial_in_line;
  logic serial_out_line;
  logic serial_out_oe;
  logic cfg_reset;
  modport dev (
    input cs_n,
    input sclk,
    input serial_in_line,
    input cfg_reset,
    output serial_out_line,
    output serial_out_oe
  );
  modport host (
    output cs_n,
    output sclk,
    output serial_in_line,
    output cfg_reset,
    input serial_out_line,
    input serial_out_oe
  );
endinterface

// ===== hdl/scp_word_rx.sv
`timescale 1ns/1ps
module scp_word_rx (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // sampled serial input
  input wire logic clr_i,
  input wire logic rise_i,
  input wire logic bit_i,
  // word assembly
  output logic [scp_pkg::CNT_BITS-1:0] cnt_o,
  output logic [scp_pkg::WORD_BITS-2:0] shift_o,
  output logic word_o,
  output logic [scp_pkg::WORD_BITS-1:0] word_data_o
);
  logic [scp_pkg::CNT_BITS-1:0] cnt_q;
  logic [scp_pkg::WORD_BITS-2:0] shift_q;
  wire last_w = rise_i && (cnt_q == scp_pkg::LAST_BIT);

  // complete word is the stored bits plus the one arriving now
  assign word_o = last_w; // [RULE6]
  assign word_data_o = {shift_q, bit_i}; // [RULE18]
  assign cnt_o = cnt_q;
  assign shift_o = shift_q;

  // clearing on deselect drops any partial word
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= '0;
      shift_q <= '0;
    end else if (clr_i) begin
      cnt_q <= '0; // [RULE7]
    end else if (rise_i) begin
      shift_q <= {shift_q[scp_pkg::WORD_BITS-3:0], bit_i}; // [RULE5]
      cnt_q <= last_w ? '0 : cnt_q + 5'h01; // [RULE8]
    end
  end
endmodule

// ===== hdl/scp_device.sv
`timescale 1ns/1ps
module scp_device (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial link
  scp_link_if.dev link,
  // converter side configuration view
  input wire logic [scp_pkg::REG_IDX_BITS-1:0] cfg_index_i,
  output logic [scp_pkg::DATA_BITS-1:0] cfg_data_o,
  output logic readout_mode_o
);
  localparam int DB = scp_pkg::DATA_BITS;
  logic sclk_q;
  logic [DB-1:0] regs_q [1:scp_pkg::REG_COUNT-1];
  logic [DB-1:0] rd_q;
  logic sdo_q;
  logic [scp_pkg::CNT_BITS-1:0] cnt;
  logic [scp_pkg::WORD_BITS-2:0] shift;
  logic word_v;
  logic [scp_pkg::WORD_BITS-1:0] word;

  // edges of the controller clock; ignored while deselected
  wire sel_w = !link.cs_n;
  wire rise_w = sel_w && link.sclk && !sclk_q; // [RULE5]
  wire fall_w = sel_w && !link.sclk && sclk_q;
  wire hw_clr_w = link.cfg_reset;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= link.sclk;
    end
  end

  scp_word_rx u_rx (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clr_i(link.cs_n || hw_clr_w),
    .rise_i(rise_w),
    .bit_i(link.serial_in_line),
    .cnt_o(cnt),
    .shift_o(shift),
    .word_o(word_v),
    .word_data_o(word)
  );

  // write decode: address first, data after
  wire [scp_pkg::ADDR_BITS-1:0] wr_addr_w = word[scp_pkg::WORD_BITS-1:DB]; // [RULE9]
  wire [DB-1:0] wr_data_w = word[DB-1:0];
  wire readout_w = regs_q[1][scp_pkg::READBACK_EN_BIT]; // [RULE11] [RULE13]
  wire wr_ok_w = word_v && (!readout_w ||
                 wr_addr_w == scp_pkg::ADDR_READBACK_CONTROL); // [RULE12] [RULE17]
  // soft reset has no storage, so it always reads back as zero
  wire soft_rst_w = wr_ok_w && wr_addr_w == scp_pkg::ADDR_SOFT_RESET_CONTROL &&
                    wr_data_w[scp_pkg::SOFT_RESET_BIT]; // [RULE2]
  wire clr_regs_w = hw_clr_w || soft_rst_w;

  // per-entry storage; addresses above the map are accepted and dropped
  genvar gi;
  generate
    for (gi = 1; gi < scp_pkg::REG_COUNT; gi++) begin : g_reg
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          regs_q[gi] <= scp_pkg::REG_RESET;
        end else if (clr_regs_w) begin
          regs_q[gi] <= scp_pkg::REG_RESET; // [RULE2]
        end else if (wr_ok_w && wr_addr_w == 8'(gi)) begin
          regs_q[gi] <= wr_data_w; // [RULE6] [RULE8]
        end
      end
    end
  endgenerate

  // readback source: address is complete after the eighth rise
  wire [scp_pkg::ADDR_BITS-1:0] rd_addr_w = shift[scp_pkg::ADDR_BITS-1:0];
  wire rd_hit_w = rd_addr_w < 8'(scp_pkg::REG_COUNT) &&
                  rd_addr_w != scp_pkg::ADDR_SOFT_RESET_CONTROL &&
                  rd_addr_w != scp_pkg::ADDR_READBACK_CONTROL; // [RULE14]
  wire [DB-1:0] rd_val_w = rd_hit_w ? regs_q[rd_addr_w[scp_pkg::REG_IDX_BITS-1:0]] :
                           scp_pkg::REG_RESET; // [RULE15]
  wire cfg_hit_w = cfg_index_i != '0;
  assign cfg_data_o = cfg_hit_w ? regs_q[cfg_index_i] : scp_pkg::REG_RESET;
  assign readout_mode_o = readout_w;

  // data moves on falls so the controller sees it stable at the next rise
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_q <= '0;
      sdo_q <= 1'b0;
    end else if (hw_clr_w || !readout_w) begin
      rd_q <= '0;
      sdo_q <= 1'b0;
    end else if (fall_w && cnt == scp_pkg::ADDR_DONE_CNT) begin
      sdo_q <= rd_val_w[DB-1]; // [RULE16] [RULE18]
      rd_q <= {rd_val_w[DB-2:0], 1'b0};
    end else if (fall_w && cnt > scp_pkg::ADDR_DONE_CNT) begin
      sdo_q <= rd_q[DB-1]; // [RULE16]
      rd_q <= {rd_q[DB-2:0], 1'b0};
    end
  end

  // output driven only in readout mode, floating otherwise and after reset
  assign link.serial_out_line = sdo_q;
  assign link.serial_out_oe = readout_w; // [RULE10] [RULE17]
endmodule

// ===== hdl/scp_host.sv
`timescale 1ns/1ps
module scp_host #(
  parameter int POWER_ON_CYCLES = scp_pkg::POWER_ON_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial link
  scp_link_if.host link,
  // user command port
  input wire logic req_i,
  input wire logic [scp_pkg::ADDR_BITS-1:0] addr_i,
  input wire logic [scp_pkg::DATA_BITS-1:0] data_i,
  output logic ready_o,
  output logic done_o,
  output logic [scp_pkg::DATA_BITS-1:0] rdata_o
);
  typedef enum logic [2:0] {
    ST_POWER,
    ST_RESET,
    ST_GAP,
    ST_IDLE,
    ST_SHIFT,
    ST_HOLD
  } scp_host_state_e;

  localparam int WB = scp_pkg::WAIT_BITS;
  scp_host_state_e state_q;
  logic [WB-1:0] wait_q;
  logic [1:0] phase_q;
  logic [scp_pkg::CNT_BITS-1:0] bit_q;
  logic [scp_pkg::WORD_BITS-1:0] tx_q;
  logic [scp_pkg::DATA_BITS-1:0] rx_q;
  logic cs_n_q;
  logic sclk_q;
  logic sdi_q;
  logic rst_q;
  logic done_q;

  // wait-end decode for the start-up sequence
  wire power_end_w = wait_q == WB'(POWER_ON_CYCLES - 1); // [RULE3]
  wire pulse_end_w = wait_q == WB'(scp_pkg::RESET_PULSE_CYCLES - 1); // [RULE1]
  wire gap_end_w = wait_q == WB'(scp_pkg::RESET_GAP_CYCLES - 1); // [RULE4]
  wire last_bit_w = bit_q == scp_pkg::LAST_BIT;
  wire rd_bit_w = bit_q >= scp_pkg::ADDR_DONE_CNT;
  wire [scp_pkg::WORD_BITS-1:0] word_w = {addr_i, data_i}; // [RULE9]

  assign ready_o = state_q == ST_IDLE;
  assign done_o = done_q;
  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.serial_in_line = sdi_q;
  assign link.cfg_reset = rst_q;

  // start-up reset sequence, then one 24-bit word per request
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_POWER;
      wait_q <= '0;
      phase_q <= '0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      rdata_o <= '0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      sdi_q <= 1'b0;
      rst_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        ST_POWER: begin
          wait_q <= wait_q + 16'h0001;
          if (power_end_w) begin
            wait_q <= '0;
            rst_q <= 1'b1; // [RULE1]
            state_q <= ST_RESET;
          end
        end
        ST_RESET: begin
          wait_q <= wait_q + 16'h0001;
          if (pulse_end_w) begin
            wait_q <= '0;
            rst_q <= 1'b0;
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          wait_q <= wait_q + 16'h0001;
          if (gap_end_w) begin
            wait_q <= '0;
            state_q <= ST_IDLE; // [RULE4]
          end
        end
        ST_IDLE: begin
          if (req_i) begin
            cs_n_q <= 1'b0;
            sdi_q <= word_w[scp_pkg::WORD_BITS-1]; // [RULE18]
            tx_q <= {word_w[scp_pkg::WORD_BITS-2:0], 1'b0};
            bit_q <= '0;
            phase_q <= '0;
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == scp_pkg::PHASE_RISE) begin
            sclk_q <= 1'b1; // [RULE5]
            if (rd_bit_w) begin
              rx_q <= {rx_q[scp_pkg::DATA_BITS-2:0], link.serial_out_line}; // [RULE16]
            end
          end
          if (phase_q == scp_pkg::PHASE_FALL) begin
            sclk_q <= 1'b0;
            if (last_bit_w) begin
              state_q <= ST_HOLD; // [RULE6]
            end else begin
              bit_q <= bit_q + 5'h01;
              sdi_q <= tx_q[scp_pkg::WORD_BITS-1];
              tx_q <= {tx_q[scp_pkg::WORD_BITS-2:0], 1'b0};
            end
          end
        end
        ST_HOLD: begin
          // one low cycle keeps select hold after the last rise
          cs_n_q <= 1'b1;
          rdata_o <= rx_q; // [RULE15]
          done_q <= 1'b1;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== tb/scp_link_props.sv
`timescale 1ns/1ps
// wire-level checks between the host and device ends
module scp_link_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic serial_out_oe,
  input wire logic cfg_reset
);
  logic [4:0] rises_q;
  logic [4:0] rises_d;
  logic sclk_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // rises per select; cleared while deselected so partial words never carry over
  assign rises_d = cs_n ? 5'h00 : rises_q + {4'h0, sclk & ~sclk_q};
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rises_q <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      rises_q <= rises_d;
      sclk_q <= sclk;
    end
  end
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock moved while deselected");
  a_bit_high_time: assert property ($rose(sclk) |=> sclk ##1 !sclk)
    else $error("serial clock high time wrong");
  a_sdi_held_high: assert property ($rose(sclk) |=> $stable(serial_in_line))
    else $error("serial input changed while clock high");
  a_sdo_after_fall: assert property ($changed(serial_out_line)
    && $past(serial_out_oe) && !$past(cs_n) |-> !sclk && $past(sclk, 2))
    else $error("serial output changed away from a fall");
  a_oe_off_reset: assert property (cfg_reset |=> !serial_out_oe)
    else $error("serial output driven after reset");
  // two cycles high keeps the pulse strictly wider than the minimum width
  a_cfg_pulse_len: assert property ($rose(cfg_reset) |-> cfg_reset [*2] ##1 !cfg_reset)
    else $error("config reset pulse width wrong");
  a_select_gap: assert property ($fell(cfg_reset) |-> cs_n [*2])
    else $error("select too soon after reset");
  a_word_rises: assert property ($rose(cs_n) |-> rises_q == 5'h18)
    else $error("select did not carry a whole word");
  c_word: cover property ($rose(cs_n));
  c_oe_on: cover property ($rose(serial_out_oe));
  c_oe_off: cover property ($fell(serial_out_oe));
endmodule

// ===== tb/serial_config_port_tb.sv
`timescale 1ns/1ps
module serial_config_port_tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] data_i = 16'h0000;
  logic [5:0] cfg_index_i = 6'h00;
  logic ready_o;
  logic done_o;
  logic readout_mode_o;
  logic [15:0] rdata_o;
  logic [15:0] cfg_data_o;
  logic [31:0] rnd = 32'hff04336e;
  logic [16:0] q [$];
  logic [16:0] note;
  int failures = 0;
  int checks = 0;
  // shortened power-on wait keeps the run small
  localparam int PON = 8;
  // 20 MHz clock
  always #25 clk_i = ~clk_i;
  scp_link_if scp_link_if_i ();
  scp_host #(.POWER_ON_CYCLES(PON)) scp_host_i (.clk_i(clk_i), .reset_i(reset_i),
    .link(scp_link_if_i.host), .req_i(req_i), .addr_i(addr_i), .data_i(data_i),
    .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o));
  scp_device scp_device_i (.clk_i(clk_i), .reset_i(reset_i), .link(scp_link_if_i.dev),
    .cfg_index_i(cfg_index_i), .cfg_data_o(cfg_data_o), .readout_mode_o(readout_mode_o));
  scp_link_props scp_link_props_i (.clk_i(clk_i), .reset_i(reset_i),
    .cs_n(scp_link_if_i.cs_n), .sclk(scp_link_if_i.sclk),
    .serial_in_line(scp_link_if_i.serial_in_line),
    .serial_out_line(scp_link_if_i.serial_out_line),
    .serial_out_oe(scp_link_if_i.serial_out_oe), .cfg_reset(scp_link_if_i.cfg_reset));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bit 16 of the note asks for a read-data compare
  task automatic cmd(input logic [7:0] a, input logic [15:0] d, input logic [16:0] n);
    int w;
    w = 0;
    while (ready_o !== 1'b1 && w < 200) begin
      @(negedge clk_i);
      w++;
    end
    // a host that never gets ready is a failure, not a silent pass
    if (w >= 200) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, ready_o, 1'b1);
    end
    q.push_back(n);
    req_i = 1'b1;
    addr_i = a;
    data_i = d;
    @(negedge clk_i);
    req_i = 1'b0;
    repeat (99) @(negedge clk_i);
  endtask
  task automatic chk_reg(input logic [5:0] idx, input logic [15:0] exp);
    @(negedge clk_i);
    cfg_index_i = idx;
    #1;
    check16(cfg_data_o, exp);
  endtask
  task automatic wrap_up();
    // notes still queued mean a transfer never finished
    if (q.size() != 0) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, q.size(), 0);
    end
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // pair each finished transfer with its oldest note; sampled mid-cycle once settled
  always @(negedge clk_i) begin
    if (done_o === 1'b1) begin
      if (q.size() == 0) begin
        failures++;
        $display("Error at %0t: got %h expected %h", $time, done_o, 1'b0);
      end else begin
        note = q.pop_front();
        if (note[16]) begin
          check16(rdata_o, note[15:0]);
        end
      end
    end
  end
  // main sequence
  initial begin
    logic [7:0] a;
    logic [15:0] d;
    repeat (12) @(negedge clk_i);
    reset_i = 1'b0;
    check16({15'h0000, scp_link_if_i.serial_out_oe}, 16'h0000);
    // config reset must wait out the power-on span, then stand two cycles
    repeat (PON - 1) @(negedge clk_i);
    check16({15'h0000, scp_link_if_i.cfg_reset}, 16'h0000);
    repeat (2) @(negedge clk_i);
    check16({15'h0000, scp_link_if_i.cfg_reset}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      a = {2'b00, rnd[5:0] | 6'h02};
      d = rnd[31:16];
      cmd(a, d, 17'h00000);
      chk_reg(a[5:0], d);
    end
    cmd(8'h00, 16'h0001, 17'h00000);
    for (int i = 0; i < 64; i++) begin
      chk_reg(i[5:0], 16'h0000);
    end
    cmd(a, d, 17'h00000);
    cmd(8'h01, 16'h0001, 17'h00000);
    check16({15'h0000, readout_mode_o}, 16'h0001);
    check16({15'h0000, scp_link_if_i.serial_out_oe}, 16'h0001);
    cmd(a, ~d, {1'b1, d});
    chk_reg(a[5:0], d);
    cmd(8'h00, 16'h0001, 17'h00000);
    chk_reg(a[5:0], d);
    cmd(8'h01, 16'h0001, 17'h10000);
    cmd(8'h01, 16'h0000, 17'h00000);
    check16({15'h0000, readout_mode_o}, 16'h0000);
    check16({15'h0000, scp_link_if_i.serial_out_oe}, 16'h0000);
    cmd(a, ~d, 17'h00000);
    chk_reg(a[5:0], ~d);
    // an address above the map must not alias onto a stored register
    cmd({2'b01, a[5:0]}, d, 17'h00000);
    chk_reg(a[5:0], ~d);
    wrap_up();
  end
  // watchdog well beyond the thirteen transfers
  initial begin
    repeat (4000) @(posedge clk_i);
    failures++;
    wrap_up();
  end
endmodule
